/* rbvc_checker.sv */
// Purpose: compare device readback bits with expected bits under a mask
// Assumes: mclk 25 MHz; refs supplied one bit per beat in step with readback from bit 0; skipBits offset dropped here in image mode
// Notes: text sources pass through an ascii-to-bit stage; a two-entry buffer decouples
`timescale 1ns/1ns
`default_nettype none
`include "rbvc_defs.svh"
module rbvc_checker
    import rbvc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // run control
    input wire logic start,
    input wire rbvc_mode_t mode,
    input wire logic [`RBVC_CNT_W-1:0] skipBits,
    input wire logic [`RBVC_CNT_W-1:0] payloadBits,
    // readback stream from the device
    input wire logic rbValid,
    input wire logic rbData,
    output logic rbReady,
    // reference source: expected and mask, text chars or bits
    input wire logic refValid,
    input wire logic refText,
    input wire logic [7:0] expChar,
    input wire logic [7:0] maskChar,
    output logic refReady,
    // results
    output logic busy,
    output logic done,
    output logic mismatch,
    output logic [`RBVC_CNT_W-1:0] mismatchCount
);
    function automatic logic charBit(input logic [7:0] c);
        return c == `RBVC_ASCII_ONE;
    endfunction
    function automatic logic isDigit(input logic [7:0] c);
        return (c == `RBVC_ASCII_ONE) || (c == `RBVC_ASCII_ZERO);
    endfunction

    rbvc_state_t state_q, state_d;
    rbvc_mode_t mode_q, mode_d;
    logic [`RBVC_CNT_W-1:0] pos_q, pos_d, cnt_q, cnt_d, len_q, len_d, skip_q, skip_d;
    logic flag_q, flag_d;
    logic hdrDone_q, hdrDone_d;
    rbvc_beat_t buf_q [2];
    rbvc_beat_t buf_d [2];
    logic [1:0] fill_q, fill_d;
    logic rbReady_q, rbReady_d, refReady_q, refReady_d;
    logic busy_q, busy_d, done_q, done_d;

    logic pairOk, push, pop, refDigit, refDrop, lastIn, inWindow;
    rbvc_beat_t inBeat;

    always_comb begin
        // text refs: header lines and stray chars are dropped before alignment
        refDigit = !refText || (isDigit(expChar) && isDigit(maskChar));
        refDrop = refValid && refReady_q && (refText && (!hdrDone_q || !refDigit));
        pairOk = rbValid && rbReady_q && refValid && refReady_q && refDigit
            && hdrDone_q;
        push = (state_q == RBVC_RUN) && pairOk;
        pop = fill_q != 2'd0;
        lastIn = (mode_q == RBVC_IMAGE) && (pos_q == len_q - `RBVC_CNT_ONE);
        inWindow = (mode_q == RBVC_TEXT) || (pos_q >= skip_q);
        inBeat.rbBit = rbData;
        inBeat.expBit = refText ? charBit(expChar) : expChar[0];
        inBeat.maskBit = refText ? charBit(maskChar) : maskChar[0];
        inBeat.lastBit = lastIn;
    end

    always_comb begin
        state_d = state_q;
        mode_d = mode_q;
        pos_d = pos_q;
        cnt_d = cnt_q;
        len_d = len_q;
        skip_d = skip_q;
        flag_d = flag_q;
        hdrDone_d = hdrDone_q;
        buf_d = buf_q;
        fill_d = fill_q;
        case (state_q)
            RBVC_IDLE, RBVC_DONE: begin
                if (start) begin
                    state_d = RBVC_HDR;
                    mode_d = mode;
                    skip_d = skipBits;
                    len_d = skipBits + payloadBits;
                    pos_d = `RBVC_CNT_ZERO;
                    cnt_d = `RBVC_CNT_ZERO;
                    flag_d = 1'b0;
                    hdrDone_d = 1'b0;
                    fill_d = 2'd0;
                end
            end
            RBVC_HDR: begin
                // text header ends at its first newline; binary refs have none
                if (!refText || (refValid && refReady_q && expChar == `RBVC_ASCII_NL)) begin
                    hdrDone_d = 1'b1;
                    state_d = RBVC_RUN;
                end
            end
            RBVC_RUN: begin
                // pad frame is just part of the compared stream in text mode
                if (push) begin
                    pos_d = pos_q + `RBVC_CNT_ONE;
                end
                if (pop) begin
                    if (!buf_q[0].maskBit && (buf_q[0].rbBit != buf_q[0].expBit)) begin
                        flag_d = 1'b1;
                        cnt_d = cnt_q + `RBVC_CNT_ONE;
                    end
                end
                if (pop && !push) begin
                    buf_d[0] = buf_q[1];
                    fill_d = fill_q - 2'd1;
                end else if (push && inWindow && !pop) begin
                    buf_d[fill_q[0]] = inBeat;
                    fill_d = fill_q + 2'd1;
                end else if (push && inWindow && pop) begin
                    if (fill_q == 2'd2) begin
                        buf_d[0] = buf_q[1];
                        buf_d[1] = inBeat;
                    end else begin
                        buf_d[0] = inBeat;
                    end
                end else if (push && pop) begin
                    buf_d[0] = buf_q[1];
                    fill_d = fill_q - 2'd1;
                end
                if (pop && buf_q[0].lastBit) begin
                    state_d = RBVC_DONE;
                    fill_d = 2'd0;
                end
            end
            default: state_d = RBVC_IDLE;
        endcase
        // text runs have no end of their own; only a reset takes one back to idle
        // the host has already turned the port to read before it raises rbValid
        rbReady_d = (state_d == RBVC_RUN) && (fill_d != 2'd2)
            && !(push && lastIn);
        // binary refs carry no header, so no beat may be taken while in HDR
        refReady_d = ((state_d == RBVC_HDR) && refText) || rbReady_d;
        busy_d = (state_d == RBVC_HDR) || (state_d == RBVC_RUN);
        done_d = state_d == RBVC_DONE;
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= RBVC_IDLE;
            mode_q <= RBVC_TEXT;
            pos_q <= `RBVC_CNT_ZERO;
            cnt_q <= `RBVC_CNT_ZERO;
            len_q <= `RBVC_CNT_ZERO;
            skip_q <= `RBVC_CNT_ZERO;
            flag_q <= 1'b0;
            hdrDone_q <= 1'b0;
            buf_q[0] <= '0;
            buf_q[1] <= '0;
            fill_q <= 2'd0;
            rbReady_q <= 1'b0;
            refReady_q <= 1'b0;
            busy_q <= 1'b0;
            done_q <= 1'b0;
        end else begin
            state_q <= state_d;
            mode_q <= mode_d;
            pos_q <= pos_d;
            cnt_q <= cnt_d;
            len_q <= len_d;
            skip_q <= skip_d;
            flag_q <= flag_d;
            hdrDone_q <= hdrDone_d;
            buf_q <= buf_d;
            fill_q <= fill_d;
            rbReady_q <= rbReady_d;
            refReady_q <= refReady_d;
            busy_q <= busy_d;
            done_q <= done_d;
        end
    end

    always_comb begin
        rbReady = rbReady_q;
        refReady = refReady_q;
        busy = busy_q;
        done = done_q;
        mismatch = flag_q;
        mismatchCount = cnt_q;
    end

    sequence s_run_start;
        (state_q == RBVC_IDLE || state_q == RBVC_DONE) && start;
    endsequence
    sequence s_bad_bit;
        state_q == RBVC_RUN && pop && !buf_q[0].maskBit && buf_q[0].rbBit != buf_q[0].expBit;
    endsequence
    sequence s_last_take;
        state_q == RBVC_RUN && push && lastIn;
    endsequence
    sequence s_last_drain;
        !rbReady && fill_q == 2'd1 ##1 done && !busy;
    endsequence

    property p_count_step;
        @(posedge mclk) disable iff (!reset_n)
        s_bad_bit |=> cnt_q == $past(cnt_q) + `RBVC_CNT_ONE;
    endproperty
    a_count_step: assert property (p_count_step) else $error("mismatch not counted");

    property p_bad_flag;
        @(posedge mclk) disable iff (!reset_n)
        s_bad_bit |=> mismatch;
    endproperty
    a_bad_flag: assert property (p_bad_flag) else $error("mismatch not flagged");

    property p_mask_skip;
        @(posedge mclk) disable iff (!reset_n)
        (state_q == RBVC_RUN && pop && buf_q[0].maskBit) |=> cnt_q == $past(cnt_q);
    endproperty
    a_mask_skip: assert property (p_mask_skip) else $error("masked bit counted");

    property p_clear_on_start;
        @(posedge mclk) disable iff (!reset_n)
        s_run_start |=> !flag_q && cnt_q == `RBVC_CNT_ZERO;
    endproperty
    a_clear_on_start: assert property (p_clear_on_start) else $error("not cleared");

    property p_start_busy;
        @(posedge mclk) disable iff (!reset_n)
        s_run_start |=> state_q == RBVC_HDR && busy && !done;
    endproperty
    a_start_busy: assert property (p_start_busy) else $error("run not started");

    property p_sticky;
        @(posedge mclk) disable iff (!reset_n)
        (flag_q && !start) |=> flag_q;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag dropped");

    property p_flag_count;
        @(posedge mclk) disable iff (!reset_n)
        flag_q == (cnt_q != `RBVC_CNT_ZERO);
    endproperty
    a_flag_count: assert property (p_flag_count) else $error("flag and count disagree");

    property p_count_hold;
        @(posedge mclk) disable iff (!reset_n)
        (state_q != RBVC_RUN && !start) |=> cnt_q == $past(cnt_q);
    endproperty
    a_count_hold: assert property (p_count_hold) else $error("count moved outside run");

    property p_end;
        @(posedge mclk) disable iff (!reset_n)
        (state_q == RBVC_RUN && pop && buf_q[0].lastBit) |=> done && !rbReady;
    endproperty
    a_end: assert property (p_end) else $error("no stop at payload end");

    property p_last_stop;
        @(posedge mclk) disable iff (!reset_n)
        s_last_take |=> s_last_drain;
    endproperty
    a_last_stop: assert property (p_last_stop) else $error("bits taken past payload");

    property p_no_accept_done;
        @(posedge mclk) disable iff (!reset_n)
        done |-> !rbReady && !refReady;
    endproperty
    a_no_accept_done: assert property (p_no_accept_done) else $error("accepts after end");

    property p_text_open;
        @(posedge mclk) disable iff (!reset_n)
        (state_q == RBVC_RUN && mode_q == RBVC_TEXT) |=> !done;
    endproperty
    a_text_open: assert property (p_text_open) else $error("text run ended early");

    property p_hdr_hold;
        @(posedge mclk) disable iff (!reset_n)
        (state_q == RBVC_HDR && refText
            && !(refValid && refReady && expChar == `RBVC_ASCII_NL)) |=> state_q == RBVC_HDR;
    endproperty
    a_hdr_hold: assert property (p_hdr_hold) else $error("header left early");

    property p_hdr_no_bit;
        @(posedge mclk) disable iff (!reset_n)
        state_q == RBVC_HDR |-> !rbReady;
    endproperty
    a_hdr_no_bit: assert property (p_hdr_no_bit) else $error("bit taken in header");

    property p_binary_hdr;
        @(posedge mclk) disable iff (!reset_n)
        (state_q == RBVC_HDR && !refText) |=> state_q == RBVC_RUN;
    endproperty
    a_binary_hdr: assert property (p_binary_hdr) else $error("binary run held");

    property p_binary_no_ref;
        @(posedge mclk) disable iff (!reset_n)
        (state_q == RBVC_HDR && !refText) |-> !refReady;
    endproperty
    a_binary_no_ref: assert property (p_binary_no_ref) else $error("binary ref lost");

    property p_skip_drop;
        @(posedge mclk) disable iff (!reset_n)
        (state_q == RBVC_RUN && mode_q == RBVC_IMAGE && push && pos_q < skip_q && !pop)
        |=> fill_q == 2'd0;
    endproperty
    a_skip_drop: assert property (p_skip_drop) else $error("bit before payload kept");

    property p_drop_no_bit;
        @(posedge mclk) disable iff (!reset_n)
        refDrop |=> pos_q == $past(pos_q);
    endproperty
    a_drop_no_bit: assert property (p_drop_no_bit) else $error("dropped char aligned");

    property p_pos_step;
        @(posedge mclk) disable iff (!reset_n)
        push |=> pos_q == $past(pos_q) + `RBVC_CNT_ONE;
    endproperty
    a_pos_step: assert property (p_pos_step) else $error("alignment slipped");

    property p_buf_bound;
        @(posedge mclk) disable iff (!reset_n)
        fill_q != 2'd3;
    endproperty
    a_buf_bound: assert property (p_buf_bound) else $error("buffer overrun");

    property p_buf_full;
        @(posedge mclk) disable iff (!reset_n)
        fill_q == 2'd2 |-> !rbReady;
    endproperty
    a_buf_full: assert property (p_buf_full) else $error("ready while full");
endmodule // rbvc_checker
`default_nettype wire

/* rbvc_defs.svh */
// Purpose: constants for the readback verify checker
// Assumes: one clock, readback bits arrive one per valid beat
// Notes: numeric values shared by the package and the checker
// Functional notes
// - mask zero compares bit, counts mismatch
// - mask one skips the bit
// - text scheme aligns at first stream bit
// - text scheme compares the pad frame too
// - binary mask mirrors image, payload replaced
// - image scheme aligns at payload start
// - image scheme stops after last payload bit
// - loader drops text header before alignment
// - ascii '1'/'0' packed into single bits
// - host turns port direction itself
`ifndef RBVC_DEFS_SVH
`define RBVC_DEFS_SVH
`define RBVC_CNT_W 32
`define RBVC_ASCII_ONE 8'h31
`define RBVC_ASCII_ZERO 8'h30
`define RBVC_ASCII_NL 8'h0A
`define RBVC_CNT_ZERO 32'h0000_0000
`define RBVC_CNT_ONE 32'h0000_0001
`endif

/* rbvc_pkg.sv */
// Purpose: shared types of the readback verify checker
// Assumes: numeric constants come from the defs header
// Notes: one beat carries a readback bit with its expected and mask bits
`default_nettype none
`include "rbvc_defs.svh"
package rbvc_pkg;
    typedef enum logic {RBVC_TEXT, RBVC_IMAGE} rbvc_mode_t;
    typedef enum logic [1:0] {RBVC_IDLE, RBVC_HDR, RBVC_RUN, RBVC_DONE} rbvc_state_t;
    // one readback bit with its reference and mask
    typedef struct packed {
        logic rbBit;
        logic expBit;
        logic maskBit;
        logic lastBit;
    } rbvc_beat_t;
endpackage
`default_nettype wire

/* rbvc_partner.sv */
// Purpose: model of the device readback port and of the reference storage
// Assumes: one bit per beat; stream and references handed over as vectors
// Notes: text refs open with a one-line header; a released line shows its inverse
`timescale 1ns/1ns
`default_nettype none
module rbvc_partner
    import rbvc_pkg::*;
(
    // clock, reset and load
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic go,
    input wire logic slow,
    input wire rbvc_mode_t mode,
    input wire logic [7:0] len,
    input wire logic [63:0] rbImg,
    input wire logic [63:0] expImg,
    input wire logic [63:0] maskImg,
    output logic finished,
    // readback port
    output logic rbValid,
    output logic rbData,
    input wire logic rbReady,
    // reference storage
    output logic refValid,
    output logic refText,
    output logic [7:0] expChar,
    output logic [7:0] maskChar,
    input wire logic refReady
);
    logic [7:0] rIdx;
    logic [7:0] fIdx;
    wire logic [7:0] hdr = (mode == RBVC_TEXT) ? 8'h02 : 8'h00;
    wire logic refTake = refValid & refReady;
    wire logic rbTake = rbValid & rbReady & refTake & (fIdx >= hdr);
    wire logic [7:0] rN = rIdx + {7'h00, rbTake};
    wire logic [7:0] fN = fIdx + {7'h00, refTake};
    wire logic [7:0] bN = fN - hdr;
    // slow mode idles one cycle after each take to stall the checker
    wire logic rbV = go && rN < len && !(slow && rbTake);
    wire logic fV = go && fN < len + hdr && !(slow && refTake);
    assign refText = (mode == RBVC_TEXT);
    function automatic logic [7:0] enc(input logic b);
        return refText ? {7'h18, b} : {7'h00, b};
    endfunction
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            {rIdx, fIdx} <= 16'h0000;
            {rbValid, refValid, rbData, finished} <= 4'h0;
            {expChar, maskChar} <= 16'h0000;
        end else if (!go) begin
            {rIdx, fIdx} <= 16'h0000;
            {rbValid, refValid, finished} <= 3'h0;
            rbData <= ~rbData;
            {expChar, maskChar} <= ~{expChar, maskChar};
        end else begin
            rIdx <= rN;
            fIdx <= fN;
            rbValid <= rbV;
            refValid <= fV;
            rbData <= rbV ? rbImg[rN[5:0]] : ~rbData;
            expChar <= !fV ? ~expChar : (fN < hdr) ? (fN == 8'h01 ? 8'h0A : 8'h48)
                : enc(expImg[bN[5:0]]);
            maskChar <= !fV ? ~maskChar : (fN < hdr) ? (fN == 8'h01 ? 8'h0A : 8'h48)
                : enc(maskImg[bN[5:0]]);
            finished <= rN >= len && fN >= len + hdr;
        end
    end
endmodule // rbvc_partner
`default_nettype wire

/* rbvc_checker_test.sv */
// Purpose: self-checking bench for the readback verify checker
// Assumes: partner model feeds readback and reference beats
// Notes: text runs never finish, so each text test starts from reset
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp, msg) begin n_tests++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("MISMATCH t=%0t %s", $time, msg); end end
module rbvc_checker_test import rbvc_pkg::*;;
    logic mclk = 1'b0;
    logic reset_n, start, go, slow, finished;
    logic rbValid, rbData, rbReady, refValid, refText, refReady, busy, done, mismatch;
    rbvc_mode_t mode;
    logic [7:0] len, expChar, maskChar;
    logic [31:0] skipBits, payloadBits, mismatchCount;
    logic [63:0] rbImg, expImg, maskImg;
    int n_mismatch = 0;
    int n_tests = 0;
    always #20 mclk = ~mclk;
    rbvc_checker i_rbvc_checker(.mclk, .reset_n, .start, .mode, .skipBits, .payloadBits,
        .rbValid, .rbData, .rbReady, .refValid, .refText, .expChar, .maskChar, .refReady,
        .busy, .done, .mismatch, .mismatchCount);
    rbvc_partner i_rbvc_partner(.mclk, .reset_n, .go, .slow, .mode, .len, .rbImg, .expImg,
        .maskImg, .finished, .rbValid, .rbData, .rbReady, .refValid, .refText, .expChar,
        .maskChar, .refReady);
    function automatic logic [31:0] expCount(input int lo, input int hi);
        logic [31:0] c;
        c = 32'h0000_0000;
        for (int i = lo; i < hi; i++) c += {31'h0, ~maskImg[i] & (rbImg[i] ^ expImg[i])};
        return c;
    endfunction
    task automatic do_reset;
        @(posedge mclk) reset_n <= 1'b0;
        repeat (4) @(posedge mclk);
        reset_n <= 1'b1;
    endtask
    task automatic run(input rbvc_mode_t m, input logic s, input logic [7:0] n,
        input logic [31:0] sk, input logic [31:0] pl, input logic [63:0] r,
        input logic [63:0] e, input logic [63:0] k);
        @(posedge mclk);
        mode <= m;
        {slow, len, skipBits, payloadBits} <= {s, n, sk, pl};
        {rbImg, expImg, maskImg} <= {r, e, k};
        {start, go} <= 2'b11;
        @(posedge mclk) start <= 1'b0;
        repeat (2) @(posedge mclk);
        for (int i = 0; i < 400 && !(finished || done); i++) @(posedge mclk);
        repeat (4) @(posedge mclk);
        go <= 1'b0;
    endtask
    task automatic test_text;
        do_reset();
        run(RBVC_TEXT, 1'b0, 8'h10, 32'h0, 32'h0, 64'hA5C3, 64'hA5C3 ^ 64'h8183, 64'h0081);
        `CHK(mismatchCount, expCount(0, 16), "text count")
        `CHK(mismatch, 1'b1, "text flag")
        `CHK(done, 1'b0, "text done")
        `CHK(busy, 1'b1, "text still running")
        $display("test_text finished");
    endtask
    task automatic test_image;
        do_reset();
        run(RBVC_IMAGE, 1'b1, 8'h0E, 32'h3, 32'h8, 64'h2D96, 64'h2D96 ^ 64'h1212, 64'h0200);
        `CHK(mismatchCount, expCount(3, 11), "image count")
        `CHK(done, 1'b1, "image done")
        `CHK(rbReady, 1'b0, "ready after end")
        `CHK(refReady, 1'b0, "ref ready after end")
        `CHK(busy, 1'b0, "image idle")
        $display("test_image finished");
    endtask
    task automatic test_rerun;
        `CHK(mismatch, 1'b1, "flag sticky")
        run(RBVC_IMAGE, 1'b0, 8'h06, 32'h0, 32'h6, 64'h3F, 64'h3E, 64'h01);
        `CHK(mismatchCount, 32'h0000_0000, "rerun count")
        `CHK(mismatch, 1'b0, "rerun flag")
        `CHK(done, 1'b1, "rerun done")
        $display("test_rerun finished");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        {reset_n, start, go, slow, len, skipBits, payloadBits} = '0;
        {rbImg, expImg, maskImg} = '0;
        mode = RBVC_TEXT;
        test_text();
        test_image();
        test_rerun();
        report_and_stop();
    end
    initial begin
        repeat (3000) @(posedge mclk);
        n_mismatch++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        report_and_stop();
    end
endmodule // rbvc_checker_test
`default_nettype wire
